/* shared/tmc_pkg.sv */
// Shared constants and types for the timer channel block
`default_nettype none
package tmc_pkg;
    localparam int ADDR_W = 8;
    localparam int CNT_W = 16;
    localparam int DEF_CHANNELS = 2;
    // Byte addresses of the timer-wide registers
    localparam logic [7:0] OFF_SC = 8'h00;
    localparam logic [7:0] OFF_CNTH = 8'h04;
    localparam logic [7:0] OFF_CNTL = 8'h08;
    localparam logic [7:0] OFF_MODH = 8'h0C;
    localparam logic [7:0] OFF_MODL = 8'h10;
    // Channel n occupies OFF_CH_BASE + n * 16
    localparam logic [7:0] OFF_CH_BASE = 8'h20;
    localparam int CH_SPAN_SH = 4;
    localparam logic [1:0] CH_SC = 2'h0;
    localparam logic [1:0] CH_VH = 2'h1;
    localparam logic [1:0] CH_VL = 2'h2;
    // Timer status/control fields
    localparam int SC_TOF = 7;
    localparam int SC_OVERFLOW_IRQ_ENABLE = 6;
    localparam int SC_CENTRE_ALIGNED_SELECT = 5;
    localparam int SC_CNTEN = 4;
    // Channel status/control fields
    localparam int CSC_FLAG = 7;
    localparam int CSC_IE = 6;
    localparam int CSC_MSH = 5;
    localparam int CSC_MSL = 4;
    localparam int CSC_ELS_HI = 3;
    localparam int CSC_ELS_LO = 2;
    localparam logic [1:0] ELS_OFF = 2'h0;
    localparam logic [1:0] ELS_TOGGLE = 2'h1;
    localparam logic [1:0] ELS_CLEAR = 2'h2;
    localparam logic [1:0] ELS_SET = 2'h3;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [15:0] CNT_ZERO = 16'h0000;
    localparam logic [15:0] CNT_ONE = 16'h0001;
    localparam logic [15:0] CNT_TOP = 16'hFFFF;
    localparam logic [15:0] MOD_RST = 16'h0000;
    typedef enum logic [1:0] {
        MODE_CAPTURE,
        MODE_COMPARE,
        MODE_EDGE_PWM,
        MODE_CENTRE_PWM
    } tmc_mode_type;
endpackage
`default_nettype wire

/* shared/tmc_flag_if.sv */
// Signals between the register logic and one event flag
`timescale 1ns/1ps
`default_nettype none
interface tmc_flag_if;
    logic event_set;
    logic read_seen;
    logic write_zero;
    logic flag;
    modport ctl (output event_set, output read_seen, output write_zero,
                 input flag);
    modport flg (input event_set, input read_seen, input write_zero,
                 output flag);
endinterface
`default_nettype wire

/* src/tmc_event_flag.sv */
// Sticky event flag with read-then-write-zero clearing
`timescale 1ns/1ps
`default_nettype none
module tmc_event_flag (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Flag controls
    tmc_flag_if.flg fl
);
    logic flag_reg;
    logic armed_reg;

    assign fl.flag = flag_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_reg <= 1'b0;
            armed_reg <= 1'b0;
        end else if (fl.event_set) begin
            // New event wins and restarts the clear sequence
            flag_reg <= 1'b1;
            armed_reg <= 1'b0;
        end else if (fl.write_zero && armed_reg) begin
            flag_reg <= 1'b0;
            armed_reg <= 1'b0;
        end else if (fl.read_seen && flag_reg) begin
            armed_reg <= 1'b1;
        end
    end
endmodule
`default_nettype wire

/* src/tmc_timer_channels.sv */
// Timer counter, modulus, channel modes, PWM buffering and event flags
// Operation
// - Non-centre, high mode bit selects edge PWM
// - Otherwise low mode bit picks capture/compare
// - Edge/level field sets edge, level, polarity
// - Field zero releases pin to general I/O
// - PWM value loads after both bytes, overflow
// - Compare channels load without waiting overflow
// - Reloaded PWM buffers update together
// - Timer control write restarts modulus pairing
// - Channel control write restarts value pairing
// - Flag sets on capture edge or match
// - Level request while enable and flag set
// - Clear by read-while-set then write zero
// - New event during clear keeps flag set
// - Free-run counter wraps FFFF to zero
// - Modulus limit wraps to zero, sets overflow
// - Up/down overflow at modulus turnaround
// - Overflow source plus one per channel
// - Writing one to flag does nothing
// - Channel enable bit readable, reset clear
`timescale 1ns/1ps
`default_nettype none
module tmc_timer_channels #(
    parameter int NUM_CH = tmc_pkg::DEF_CHANNELS,
    parameter int AW = tmc_pkg::ADDR_W
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic [AW-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Channel pins
    input wire logic [NUM_CH-1:0] ch_pin_in,
    output logic [NUM_CH-1:0] ch_pin_out,
    output logic [NUM_CH-1:0] ch_pin_oe,
    // Interrupt requests
    output logic overflow_irq,
    output logic [NUM_CH-1:0] channel_irq
);
    localparam int CW = tmc_pkg::CNT_W;

    function automatic logic [AW-1:0] ch_addr(input int n,
                                              input logic [1:0] r);
        ch_addr = AW'(tmc_pkg::OFF_CH_BASE)
                  + AW'(n << tmc_pkg::CH_SPAN_SH)
                  + AW'({r, 2'b00});
    endfunction

    function automatic tmc_pkg::tmc_mode_type mode_of(input logic cp,
                                                      input logic mh,
                                                      input logic ml);
        if (cp) begin
            mode_of = tmc_pkg::MODE_CENTRE_PWM;
        end else if (mh) begin
            mode_of = tmc_pkg::MODE_EDGE_PWM;
        end else if (ml) begin
            mode_of = tmc_pkg::MODE_COMPARE;
        end else begin
            mode_of = tmc_pkg::MODE_CAPTURE;
        end
    endfunction

    // Bus phases
    logic setup_ph;
    logic access_ph;
    logic wr_en;
    logic rd_setup;
    logic [7:0] wbyte;
    assign setup_ph = psel & ~penable;
    assign access_ph = psel & penable;
    assign wr_en = access_ph & pwrite;
    assign rd_setup = setup_ph & ~pwrite;
    assign wbyte = pwdata[7:0];

    // Timer-wide address decode
    logic hit_sc;
    logic hit_cnth;
    logic hit_cntl;
    logic hit_modh;
    logic hit_modl;
    logic [NUM_CH-1:0] ch_any_hit;
    logic mapped;
    assign hit_sc = paddr == AW'(tmc_pkg::OFF_SC);
    assign hit_cnth = paddr == AW'(tmc_pkg::OFF_CNTH);
    assign hit_cntl = paddr == AW'(tmc_pkg::OFF_CNTL);
    assign hit_modh = paddr == AW'(tmc_pkg::OFF_MODH);
    assign hit_modl = paddr == AW'(tmc_pkg::OFF_MODL);
    assign mapped = hit_sc | hit_cnth | hit_cntl | hit_modh | hit_modl
                    | (|ch_any_hit);

    logic sc_wr;
    logic cnt_wr;
    assign sc_wr = wr_en & hit_sc;
    assign cnt_wr = wr_en & (hit_cnth | hit_cntl);

    // Timer control state
    logic overflow_irq_enable_reg;
    logic centre_aligned_select_reg;
    logic cnt_en_reg;
    logic [CW-1:0] cnt_reg;
    logic down_reg;
    logic [CW-1:0] mod_reg;
    logic [7:0] mod_hi_buf_reg;
    logic [7:0] mod_lo_buf_reg;
    logic mod_hi_wr_reg;
    logic mod_lo_wr_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            overflow_irq_enable_reg <= 1'b0;
            centre_aligned_select_reg <= 1'b0;
            cnt_en_reg <= 1'b0;
        end else if (sc_wr) begin
            overflow_irq_enable_reg <= wbyte[tmc_pkg::SC_OVERFLOW_IRQ_ENABLE];
            centre_aligned_select_reg <= wbyte[tmc_pkg::SC_CENTRE_ALIGNED_SELECT];
            cnt_en_reg <= wbyte[tmc_pkg::SC_CNTEN];
        end
    end

    // Counter and overflow detection
    logic at_top;
    logic ovf_evt;
    assign at_top = (mod_reg == tmc_pkg::MOD_RST) ?
                    (cnt_reg == tmc_pkg::CNT_TOP) :
                    (cnt_reg == mod_reg);
    // Overflow marks a wrap (up) or the turnaround at the top (up/down)
    assign ovf_evt = cnt_en_reg & at_top
                     & (~centre_aligned_select_reg | ~down_reg);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= tmc_pkg::CNT_ZERO;
            down_reg <= 1'b0;
        end else if (cnt_wr) begin
            cnt_reg <= tmc_pkg::CNT_ZERO;
            down_reg <= 1'b0;
        end else if (cnt_en_reg) begin
            if (!centre_aligned_select_reg) begin
                down_reg <= 1'b0;
                if (at_top) begin
                    cnt_reg <= tmc_pkg::CNT_ZERO;
                end else begin
                    cnt_reg <= cnt_reg + tmc_pkg::CNT_ONE;
                end
            end else if (!down_reg) begin
                if (at_top) begin
                    down_reg <= 1'b1;
                    cnt_reg <= cnt_reg - tmc_pkg::CNT_ONE;
                end else begin
                    cnt_reg <= cnt_reg + tmc_pkg::CNT_ONE;
                end
            end else if (cnt_reg == tmc_pkg::CNT_ZERO) begin
                down_reg <= 1'b0;
                cnt_reg <= cnt_reg + tmc_pkg::CNT_ONE;
            end else begin
                cnt_reg <= cnt_reg - tmc_pkg::CNT_ONE;
            end
        end
    end

    // Modulus byte pairing
    logic mod_load;
    assign mod_load = mod_hi_wr_reg & mod_lo_wr_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mod_reg <= tmc_pkg::MOD_RST;
            mod_hi_buf_reg <= tmc_pkg::BYTE_ZERO;
            mod_lo_buf_reg <= tmc_pkg::BYTE_ZERO;
            mod_hi_wr_reg <= 1'b0;
            mod_lo_wr_reg <= 1'b0;
        end else if (sc_wr) begin
            mod_hi_wr_reg <= 1'b0;
            mod_lo_wr_reg <= 1'b0;
        end else begin
            if (mod_load) begin
                mod_reg <= {mod_hi_buf_reg, mod_lo_buf_reg};
            end
            if (wr_en && hit_modh) begin
                mod_hi_buf_reg <= wbyte;
                mod_hi_wr_reg <= 1'b1;
            end else if (mod_load) begin
                mod_hi_wr_reg <= 1'b0;
            end
            if (wr_en && hit_modl) begin
                mod_lo_buf_reg <= wbyte;
                mod_lo_wr_reg <= 1'b1;
            end else if (mod_load) begin
                mod_lo_wr_reg <= 1'b0;
            end
        end
    end

    // Overflow flag
    tmc_flag_if tof_if ();
    assign tof_if.event_set = ovf_evt;
    assign tof_if.read_seen = rd_setup & hit_sc;
    assign tof_if.write_zero = sc_wr & ~wbyte[tmc_pkg::SC_TOF];
    tmc_event_flag tof_flag (
        .pclk(pclk),
        .presetn(presetn),
        .fl(tof_if.flg)
    );
    assign overflow_irq = tof_if.flag & overflow_irq_enable_reg;

    // Channels
    tmc_flag_if ch_if [NUM_CH] ();
    logic [7:0] ch_rd [NUM_CH];
    logic [7:0] ch_or [NUM_CH+1];
    assign ch_or[0] = tmc_pkg::BYTE_ZERO;

    for (genvar n = 0; n < NUM_CH; n++) begin : ch_g
        logic ie_reg;
        logic msh_reg;
        logic msl_reg;
        logic [1:0] els_reg;
        logic [CW-1:0] val_reg;
        logic [7:0] vh_buf_reg;
        logic [7:0] vl_buf_reg;
        logic vh_wr_reg;
        logic vl_wr_reg;
        logic pin_s1_reg;
        logic pin_s2_reg;
        logic pin_s3_reg;
        logic out_reg;
        tmc_pkg::tmc_mode_type mode;
        logic hsc;
        logic hvh;
        logic hvl;
        logic is_pwm;
        logic is_cap;
        logic csc_wr;
        logic rise;
        logic fall;
        logic cap_evt;
        logic match;
        logic val_load;

        assign hsc = paddr == ch_addr(n, tmc_pkg::CH_SC);
        assign hvh = paddr == ch_addr(n, tmc_pkg::CH_VH);
        assign hvl = paddr == ch_addr(n, tmc_pkg::CH_VL);
        assign ch_any_hit[n] = hsc | hvh | hvl;
        assign csc_wr = wr_en & hsc;
        assign mode = mode_of(centre_aligned_select_reg, msh_reg, msl_reg);
        assign is_pwm = (mode == tmc_pkg::MODE_EDGE_PWM)
                        | (mode == tmc_pkg::MODE_CENTRE_PWM);
        assign is_cap = mode == tmc_pkg::MODE_CAPTURE;

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                ie_reg <= 1'b0;
                msh_reg <= 1'b0;
                msl_reg <= 1'b0;
                els_reg <= tmc_pkg::ELS_OFF;
            end else if (csc_wr) begin
                ie_reg <= wbyte[tmc_pkg::CSC_IE];
                msh_reg <= wbyte[tmc_pkg::CSC_MSH];
                msl_reg <= wbyte[tmc_pkg::CSC_MSL];
                els_reg <= {wbyte[tmc_pkg::CSC_ELS_HI],
                            wbyte[tmc_pkg::CSC_ELS_LO]};
            end
        end

        // Pin sampling, two stages before edge detection
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                pin_s1_reg <= 1'b0;
                pin_s2_reg <= 1'b0;
                pin_s3_reg <= 1'b0;
            end else begin
                pin_s1_reg <= ch_pin_in[n];
                pin_s2_reg <= pin_s1_reg;
                pin_s3_reg <= pin_s2_reg;
            end
        end
        assign rise = pin_s2_reg & ~pin_s3_reg;
        assign fall = ~pin_s2_reg & pin_s3_reg;
        // Field 01 rising, 10 falling, 11 both, 00 capture disabled
        assign cap_evt = is_cap & ((els_reg[0] & rise)
                                   | (els_reg[1] & fall));
        // Only a ticking counter matches, so a stopped one cannot refire
        assign match = cnt_en_reg & ~is_cap & (cnt_reg == val_reg);
        // Compare loads at once; PWM waits for the shared overflow
        assign val_load = vh_wr_reg & vl_wr_reg
                          & (~is_pwm | ovf_evt);

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                val_reg <= tmc_pkg::CNT_ZERO;
                vh_buf_reg <= tmc_pkg::BYTE_ZERO;
                vl_buf_reg <= tmc_pkg::BYTE_ZERO;
                vh_wr_reg <= 1'b0;
                vl_wr_reg <= 1'b0;
            end else begin
                if (cap_evt) begin
                    val_reg <= cnt_reg;
                end else if (val_load) begin
                    val_reg <= {vh_buf_reg, vl_buf_reg};
                end
                if (csc_wr) begin
                    vh_wr_reg <= 1'b0;
                    vl_wr_reg <= 1'b0;
                end else begin
                    if (wr_en && hvh) begin
                        vh_buf_reg <= wbyte;
                        vh_wr_reg <= 1'b1;
                    end else if (val_load) begin
                        vh_wr_reg <= 1'b0;
                    end
                    if (wr_en && hvl) begin
                        vl_buf_reg <= wbyte;
                        vl_wr_reg <= 1'b1;
                    end else if (val_load) begin
                        vl_wr_reg <= 1'b0;
                    end
                end
            end
        end

        // Pin level: compare acts on match, PWM follows the duty compare
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                out_reg <= 1'b0;
            end else if (is_pwm) begin
                // Field 10 high-true, x1 low-true
                out_reg <= (cnt_reg < val_reg) ^ els_reg[0];
            end else if (match) begin
                unique case (els_reg)
                    tmc_pkg::ELS_TOGGLE: out_reg <= ~out_reg;
                    tmc_pkg::ELS_CLEAR: out_reg <= 1'b0;
                    tmc_pkg::ELS_SET: out_reg <= 1'b1;
                    tmc_pkg::ELS_OFF: out_reg <= out_reg;
                endcase
            end
        end
        assign ch_pin_out[n] = out_reg;
        // Zero field hands the pin back even if the channel runs
        assign ch_pin_oe[n] = (els_reg != tmc_pkg::ELS_OFF)
                              & ~is_cap;

        assign ch_if[n].event_set = cap_evt | match;
        assign ch_if[n].read_seen = rd_setup & hsc;
        assign ch_if[n].write_zero = csc_wr
                                     & ~wbyte[tmc_pkg::CSC_FLAG];
        tmc_event_flag ch_flag (
            .pclk(pclk),
            .presetn(presetn),
            .fl(ch_if[n].flg)
        );
        assign channel_irq[n] = ch_if[n].flag & ie_reg;

        assign ch_rd[n] = hsc ? {ch_if[n].flag, ie_reg, msh_reg, msl_reg,
                                 els_reg, 2'b00} :
                          hvh ? val_reg[15:8] :
                          hvl ? val_reg[7:0] : tmc_pkg::BYTE_ZERO;
        assign ch_or[n+1] = ch_or[n] | ch_rd[n];
    end

    // Read selection
    logic [7:0] rd_byte;
    logic [7:0] tmr_sc_rd;
    assign tmr_sc_rd = {tof_if.flag, overflow_irq_enable_reg, centre_aligned_select_reg, cnt_en_reg,
                        4'h0};
    assign rd_byte = hit_sc ? tmr_sc_rd :
                     hit_cnth ? cnt_reg[15:8] :
                     hit_cntl ? cnt_reg[7:0] :
                     hit_modh ? mod_reg[15:8] :
                     hit_modl ? mod_reg[7:0] : ch_or[NUM_CH];

    // Read data captured in setup, held through the access phase
    logic [31:0] prdata_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h0000_0000;
        end else if (rd_setup) begin
            prdata_reg <= {24'h00_0000, rd_byte};
        end
    end
    assign prdata = prdata_reg;
    assign pready = 1'b1;
    assign pslverr = access_ph & ~mapped;
endmodule
`default_nettype wire

/* tb/tmc_timer_channels_sva.sv */
// Port-level checker for the timer channel block
`timescale 1ns/1ps
`default_nettype none
module tmc_timer_channels_sva #(
    parameter int NUM_CH = 2,
    parameter int AW = 8
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic [AW-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Pins and requests
    input wire logic [NUM_CH-1:0] ch_pin_in,
    input wire logic [NUM_CH-1:0] ch_pin_out,
    input wire logic [NUM_CH-1:0] ch_pin_oe,
    input wire logic overflow_irq,
    input wire logic [NUM_CH-1:0] channel_irq
);
    logic [7:0] a8;
    logic wr_edge;
    logic mapped;
    logic [7:0] tc_reg;
    logic [7:0] c0_reg;
    logic [7:0] c1_reg;
    logic [1:0] oe_exp;
    assign a8 = 8'(paddr);
    assign wr_edge = psel && penable && pwrite && pready;
    assign mapped = a8 inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h20,
                               8'h24, 8'h28, 8'h30, 8'h34, 8'h38};
    // Capture mode is the only mode that leaves a configured pin undriven
    assign oe_exp[0] = (c0_reg[3:2] != 2'h0) &&
                       (tc_reg[5] || c0_reg[5] || c0_reg[4]);
    assign oe_exp[1] = (c1_reg[3:2] != 2'h0) &&
                       (tc_reg[5] || c1_reg[5] || c1_reg[4]);
    // Shadow copies of the control bytes as software wrote them
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tc_reg <= 8'h00;
            c0_reg <= 8'h00;
            c1_reg <= 8'h00;
        end else if (wr_edge) begin
            if (a8 == 8'h00) tc_reg <= pwdata[7:0];
            if (a8 == 8'h20) c0_reg <= pwdata[7:0];
            if (a8 == 8'h30) c1_reg <= pwdata[7:0];
        end
    end
    a_oe_decode: assert property (@(posedge pclk) disable iff (!presetn)
        ch_pin_oe[1:0] == oe_exp) else $error("pin enable decode wrong");
    a_irq_needs_en: assert property (@(posedge pclk) disable iff (!presetn)
        (channel_irq[1:0] & ~{c1_reg[6], c0_reg[6]}) == 2'b00)
        else $error("channel request without enable");
    a_ovf_needs_en: assert property (@(posedge pclk) disable iff (!presetn)
        !tc_reg[6] |-> !overflow_irq) else $error("overflow request without enable");
    a_ch0_irq_hold: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(channel_irq[0]) |-> $past(wr_edge && a8 == 8'h20))
        else $error("channel 0 request dropped without write");
    a_ch1_irq_hold: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(channel_irq[1]) |-> $past(wr_edge && a8 == 8'h30))
        else $error("channel 1 request dropped without write");
    a_ovf_irq_hold: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(overflow_irq) |-> $past(wr_edge && a8 == 8'h00))
        else $error("overflow request dropped without write");
    a_reset_quiet: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(presetn) |-> ch_pin_out[1:0] == 2'b00 && !overflow_irq &&
        channel_irq[1:0] == 2'b00) else $error("outputs active after reset");
    a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable |-> pslverr == !mapped) else $error("slave error wrong");
endmodule
bind tmc_timer_channels tmc_timer_channels_sva #(.NUM_CH(NUM_CH), .AW(AW)) u_sva (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ch_pin_in(ch_pin_in),
    .ch_pin_out(ch_pin_out), .ch_pin_oe(ch_pin_oe),
    .overflow_irq(overflow_irq), .channel_irq(channel_irq));
`default_nettype wire

/* tb/tb.sv */
// Self-checking bench for the timer channel block
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam logic [7:0] SC = tmc_pkg::OFF_SC;
    localparam logic [7:0] MH = tmc_pkg::OFF_MODH;
    localparam logic [7:0] ML = tmc_pkg::OFF_MODL;
    localparam logic [7:0] A0 = tmc_pkg::OFF_CH_BASE;
    localparam logic [7:0] A1 = tmc_pkg::OFF_CH_BASE + 8'h10;
    // Decode table, entry 0 in the low byte
    localparam logic [47:0] SCT = 48'h2020_0000_0000;
    localparam logic [47:0] CCT = 48'h2004_2410_1404;
    localparam logic [5:0] OET = 6'b011010;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [1:0] pin_in = 2'b00;
    logic [1:0] pin_out;
    logic [1:0] pin_oe;
    logic ovf_irq;
    logic [1:0] ch_irq;
    logic [7:0] q;
    logic e;
    int err_count = 0;
    int cmp_count = 0;
    always #12.5 pclk = ~pclk;
    tmc_timer_channels #(.NUM_CH(2), .AW(8)) dut (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ch_pin_in(pin_in), .ch_pin_out(pin_out), .ch_pin_oe(pin_oe),
        .overflow_irq(ovf_irq), .channel_irq(ch_irq));
    task automatic complete_run();
        if (err_count == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic check(input string name, input logic [7:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s exp %h seen %h", name, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // Request held until pready is sampled; an idle cycle follows
    task automatic xfer(input logic [7:0] a, input logic w, input logic [7:0] d);
        int n;
        n = 0;
        paddr <= a;
        pwrite <= w;
        pwdata <= {24'h00_0000, d};
        psel <= 1'b1;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        // A wait that runs out counts as a mismatch
        check("pready", {7'h00, pready}, 8'h01);
        q = prdata[7:0];
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [7:0] a, d);
        xfer(a, 1'b1, d);
    endtask
    task automatic rd(input logic [7:0] a);
        xfer(a, 1'b0, 8'h00);
    endtask
    task automatic t_reset();
        rd(A0);
        check("ch0 ctrl", q, 8'h00);
        rd(ML);
        check("mod low", q, 8'h00);
        check("pin oe", {6'h00, pin_oe}, 8'h00);
        rd(8'hFC);
        check("slverr", {7'h00, e}, 8'h01);
    endtask
    task automatic t_compare();
        wr(A0, 8'h5C);
        wr(A0 + 8'h04, 8'h00);
        wr(A0 + 8'h08, 8'h10);
        rd(A0 + 8'h08);
        check("cmp value", q, 8'h10);
        wr(SC, 8'h10);
        for (int i = 0; i < 100 && ch_irq[0] !== 1'b1; i++) @(posedge pclk);
        check("cmp irq", {7'h00, ch_irq[0]}, 8'h01);
        check("cmp pin", {6'h00, pin_oe[0], pin_out[0]}, 8'h03);
        wr(A0, 8'hDC);
        check("flag w1", {7'h00, ch_irq[0]}, 8'h01);
        wr(A0, 8'h5C);
        check("no read", {7'h00, ch_irq[0]}, 8'h01);
        rd(A0);
        check("flag rd", q, 8'hDC);
        wr(A0, 8'h5C);
        check("cleared", {7'h00, ch_irq[0]}, 8'h00);
    endtask
    task automatic t_capture();
        wr(A1, 8'h04);
        pin_in[1] <= 1'b1;
        tick(6);
        rd(A1);
        check("cap rise", q, 8'h84);
        check("poll only", {7'h00, ch_irq[1]}, 8'h00);
        wr(A1, 8'h04);
        pin_in[1] <= 1'b0;
        tick(6);
        rd(A1);
        check("cap fall", q, 8'h04);
        wr(A1, 8'h0C);
        pin_in[1] <= 1'b1;
        tick(6);
        rd(A1);
        pin_in[1] <= 1'b0;
        tick(6);
        wr(A1, 8'h0C);
        rd(A1);
        check("cap keep", q, 8'h8C);
    endtask
    task automatic t_pwm();
        int h0;
        int h1;
        h0 = 0;
        h1 = 0;
        wr(SC, 8'h00);
        wr(tmc_pkg::OFF_CNTL, 8'h00);
        wr(MH, 8'h00);
        wr(ML, 8'h20);
        wr(MH, 8'h01);
        wr(SC, 8'h00);
        wr(ML, 8'h30);
        rd(MH);
        check("mod high", q, 8'h00);
        rd(ML);
        check("mod low", q, 8'h20);
        wr(A0, 8'h28);
        wr(A0 + 8'h04, 8'h00);
        wr(A0 + 8'h08, 8'h08);
        wr(A1, 8'h28);
        wr(A1 + 8'h04, 8'h01);
        wr(A1, 8'h28);
        wr(A1 + 8'h08, 8'h04);
        wr(A1 + 8'h04, 8'h00);
        rd(A0 + 8'h08);
        check("pwm hold", q, 8'h10);
        wr(SC, 8'h50);
        for (int i = 0; i < 200 && ovf_irq !== 1'b1; i++) @(posedge pclk);
        // One full period of 33 counts, high while count below value
        repeat (33) begin
            @(posedge pclk);
            h0 += int'(pin_out[0]);
            h1 += int'(pin_out[1]);
        end
        check("pwm duty0", 8'(h0), 8'h08);
        check("pwm duty1", 8'(h1), 8'h04);
        rd(SC);
        check("ovf flag", q, 8'hD0);
        wr(SC, 8'h50);
        check("ovf clr", {7'h00, ovf_irq}, 8'h00);
        rd(A0 + 8'h08);
        check("pwm load0", q, 8'h08);
        rd(A1 + 8'h08);
        check("pwm load1", q, 8'h04);
        rd(A1 + 8'h04);
        check("pwm pair1", q, 8'h00);
        check("pwm oe", {6'h00, pin_oe}, 8'h03);
    endtask
    task automatic t_centre();
        int n;
        n = 0;
        wr(SC, 8'h70);
        for (int i = 0; i < 200 && ovf_irq !== 1'b1; i++) @(posedge pclk);
        rd(SC);
        wr(SC, 8'h70);
        while (ovf_irq !== 1'b1 && n < 200) begin
            @(posedge pclk);
            n++;
        end
        // Up counting would give about half this gap
        check("centre gap", {7'h00, n > 40 && n < 70}, 8'h01);
    endtask
    task automatic t_decode();
        for (int i = 0; i < 6; i++) begin
            wr(SC, SCT[8*i +: 8]);
            wr(A1, CCT[8*i +: 8]);
            check("decode oe", {7'h00, pin_oe[1]}, {7'h00, OET[i]});
        end
    endtask
    // Free-running wrap takes a full 16-bit count
    task automatic t_wrap();
        int n;
        logic p0;
        n = 0;
        rd(SC);
        wr(SC, 8'h00);
        wr(MH, 8'h00);
        wr(ML, 8'h00);
        wr(tmc_pkg::OFF_CNTL, 8'h00);
        wr(A0, 8'h14);
        rd(ML);
        check("mod zero", q, 8'h00);
        p0 = pin_out[0];
        wr(SC, 8'h50);
        while (ovf_irq !== 1'b1 && n < 66000) begin
            @(posedge pclk);
            n++;
        end
        check("wrap gap", {7'h00, n > 65530 && n < 65540}, 8'h01);
        check("cmp toggle", {7'h00, pin_out[0]}, {7'h00, ~p0});
    endtask
    initial begin
        tick(10);
        presetn <= 1'b1;
        tick(1);
        t_reset();
        t_compare();
        t_capture();
        t_pwm();
        t_centre();
        t_decode();
        t_wrap();
        complete_run();
    end
    initial begin
        tick(69000);
        err_count++;
        complete_run();
    end
endmodule
`default_nettype wire
